// ### src/vcmon_defs.svh
// constants for the vc-12 non-intrusive path monitor
`ifndef VCMON_DEFS_SVH
`define VCMON_DEFS_SVH
// frame geometry: 140 bytes per 500 us multiframe, v5 first
`define VCMON_FRAME_BYTES 140
`define VCMON_J2_POS 35
`define VCMON_K4_POS 105
// v5 bit positions, bit 1 is msb (index 7)
`define VCMON_V5_BIP_HI 7
`define VCMON_V5_BIP_LO 6
`define VCMON_V5_REI 5
`define VCMON_V5_RDI 0
`define VCMON_V5_SL_HI 3
`define VCMON_V5_SL_LO 1
// signal labels
`define VCMON_SL_AIS 3'h7
`define VCMON_SL_UNEQ 3'h0
// persistence counts in frames
`define VCMON_AIS_FRAMES 3'h5
`define VCMON_DEF_FRAMES 3'h5
// trace length and degrade defaults
`define VCMON_TRACE_LEN 16
`define VCMON_DEG_THR 16'h0010
// interrupt bit layout
`define VCMON_IRQ_W 6
`define VCMON_IRQ_AIS 0
`define VCMON_IRQ_UNEQ 1
`define VCMON_IRQ_TIM 2
`define VCMON_IRQ_RDI 3
`define VCMON_IRQ_DEG 4
`define VCMON_IRQ_SEC 5
// register byte offsets
`define VCMON_REG_CTRL 8'h00
`define VCMON_REG_STAT 8'h04
`define VCMON_REG_IRQ 8'h08
`define VCMON_REG_MASK 8'h0c
`define VCMON_REG_NEBC 8'h10
`define VCMON_REG_FEBC 8'h14
`define VCMON_REG_EXTI 8'h18
`define VCMON_REG_ACCEPTED_TRACE_ID 8'h28
`define VCMON_REG_DEGT 8'h38
`define VCMON_CTRL_RST 32'h0000_0001
`endif

// ### src/vcmon_pkg.sv
// types for the vc-12 non-intrusive path monitor
package vcmon_pkg;
    // fault causes reported to management
    typedef struct packed {
        logic unequipped_cause;
        logic trace_mismatch_cause;
        logic degraded_cause;
        logic remote_defect_cause;
        logic server_fail_cause;
    } vcmon_cause_s;
    // performance primitives per second
    typedef struct packed {
        logic near_defect_second;
        logic far_defect_second;
        logic [15:0] near_block_error_count;
        logic [15:0] far_block_error_count;
    } vcmon_perf_s;
    // termination point mode
    typedef enum logic [1:0] {
        VCMON_TP_NONE = 2'b00,
        VCMON_TP_MON = 2'b01,
        VCMON_TP_TERM = 2'b10
    } vcmon_termination_point_mode_e;
    // wishbone transaction state
    typedef enum logic [0:0] {
        VCMON_WB_IDLE = 1'b0,
        VCMON_WB_ACK = 1'b1
    } vcmon_wb_e;
endpackage

// ### src/vcmon_top.sv
// vc-12 non-intrusive path monitor with wishbone registers
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`include "vcmon_defs.svh"

module vcmon_top #(
    parameter int TRACE_LEN = `VCMON_TRACE_LEN,
    parameter int FRAME_BYTES = `VCMON_FRAME_BYTES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // characteristic information stream
    input wire logic ci_data,
    input wire logic ci_clk,
    input wire logic ci_frame_start,
    input wire logic incoming_server_fail,
    // management and equipment inputs
    input wire logic one_second,
    input wire logic equipment_defect,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // atomic outputs and causes
    output logic trail_signal_fail,
    output logic trail_signal_degrade,
    output vcmon_pkg::vcmon_cause_s cause,
    output vcmon_pkg::vcmon_perf_s perf,
    output logic irq
);
    // input synchronisers, two stages each
    logic [3:0] sync1_reg, sync2_reg;
    logic ck_prev_reg;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            ck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {incoming_server_fail, ci_frame_start, ci_data, ci_clk};
            sync2_reg <= sync1_reg;
            ck_prev_reg <= sync2_reg[0];
        end
    end
    logic ck_rise, s_data, s_fs, s_ssf;
    assign ck_rise = sync2_reg[0] & ~ck_prev_reg;
    assign s_data = sync2_reg[1];
    assign s_fs = sync2_reg[2];
    assign s_ssf = sync2_reg[3];

    // registers written by software
    logic [31:0] ctrl_reg;
    logic [`VCMON_IRQ_W-1:0] mask_reg;
    logic [15:0] deg_thr_reg;
    logic [7:0] exp_ti_reg [TRACE_LEN];
    logic mismatch_detect_disable, remote_defect_report_en, server_fail_report_en;
    logic monitoring_enabled;
    vcmon_pkg::vcmon_termination_point_mode_e termination_point_mode;
    assign termination_point_mode = vcmon_pkg::vcmon_termination_point_mode_e'(ctrl_reg[5:4]);
    assign mismatch_detect_disable = ctrl_reg[1];
    assign remote_defect_report_en = ctrl_reg[2];
    assign server_fail_report_en = ctrl_reg[3];
    // monitored only in the monitor mode
    assign monitoring_enabled = (termination_point_mode == vcmon_pkg::VCMON_TP_MON);

    // bit and byte position within the frame; msb first
    logic [2:0] bit_reg;
    logic [7:0] byte_reg;
    logic [7:0] shift_reg;
    logic frame_ok_reg;
    logic [7:0] cur_byte;
    logic byte_done;
    assign cur_byte = {shift_reg[6:0], s_data};
    assign byte_done = ck_rise & (bit_reg == 3'h7);
    always_ff @(posedge mclk) begin
        if (reset) begin
            bit_reg <= 3'h0;
            byte_reg <= 8'h0;
            shift_reg <= 8'h0;
            frame_ok_reg <= 1'b0;
        end else if (ck_rise) begin
            shift_reg <= cur_byte;
            if (s_fs) begin
                bit_reg <= 3'h1;
                byte_reg <= 8'h0;
                frame_ok_reg <= 1'b1;
            end else begin
                bit_reg <= bit_reg + 3'h1;
                if (bit_reg == 3'h7) begin
                    byte_reg <= (byte_reg == 8'(FRAME_BYTES - 1)) ? 8'h0 : byte_reg + 8'h1;
                end
            end
        end
    end
    logic v5_done, j2_done;
    assign v5_done = byte_done & frame_ok_reg & (byte_reg == 8'h0);
    assign j2_done = byte_done & frame_ok_reg & (byte_reg == 8'(`VCMON_J2_POS));
    // k4 byte is never looked at by any process

    // bip-2 accumulation; prev holds parity of the previous frame
    logic [1:0] bip_acc_reg, bip_prev_reg;
    logic bip_valid_reg;
    logic [1:0] byte_bip;
    assign byte_bip = {^{cur_byte[7], cur_byte[5], cur_byte[3], cur_byte[1]},
                       ^{cur_byte[6], cur_byte[4], cur_byte[2], cur_byte[0]}};
    always_ff @(posedge mclk) begin
        if (reset) begin
            bip_acc_reg <= 2'h0;
            bip_prev_reg <= 2'h0;
            bip_valid_reg <= 1'b0;
        end else if (v5_done) begin
            bip_prev_reg <= bip_acc_reg;
            bip_acc_reg <= byte_bip; // v5 included
            bip_valid_reg <= 1'b1;
        end else if (byte_done & frame_ok_reg) begin
            bip_acc_reg <= bip_acc_reg ^ byte_bip;
        end
    end

    // v5 extraction: per-frame error pulses and label
    logic near_errored_block, far_errored_block;
    logic [2:0] label_reg;
    logic rdi_bit_reg;
    always_ff @(posedge mclk) begin
        if (reset) begin
            near_errored_block <= 1'b0;
            far_errored_block <= 1'b0;
            label_reg <= 3'h1;
            rdi_bit_reg <= 1'b0;
        end else begin
            near_errored_block <= v5_done & bip_valid_reg &
                (cur_byte[`VCMON_V5_BIP_HI:`VCMON_V5_BIP_LO] != bip_acc_reg);
            far_errored_block <= v5_done & cur_byte[`VCMON_V5_REI];
            if (v5_done) begin
                label_reg <= cur_byte[`VCMON_V5_SL_HI:`VCMON_V5_SL_LO];
                rdi_bit_reg <= cur_byte[`VCMON_V5_RDI];
            end
        end
    end
    logic v5_seen_reg;
    always_ff @(posedge mclk) begin
        if (reset) v5_seen_reg <= 1'b0;
        else v5_seen_reg <= v5_done;
    end

    // ais persistence counter
    logic alarm_indication_defect;
    logic [2:0] ais_cnt_reg;
    always_ff @(posedge mclk) begin
        if (reset) begin
            alarm_indication_defect <= 1'b0;
            ais_cnt_reg <= 3'h0;
        end else if (v5_seen_reg) begin
            if ((label_reg == `VCMON_SL_AIS) != alarm_indication_defect) begin
                if (ais_cnt_reg == `VCMON_AIS_FRAMES - 3'h1) begin
                    alarm_indication_defect <= ~alarm_indication_defect;
                    ais_cnt_reg <= 3'h0;
                end else begin
                    ais_cnt_reg <= ais_cnt_reg + 3'h1;
                end
            end else begin
                ais_cnt_reg <= 3'h0;
            end
        end
    end
    logic gate_fail;
    assign gate_fail = s_ssf | alarm_indication_defect;

    // unequipped and remote defect, five-frame persistence; only remote defect gated
    logic unequipped_defect, remote_defect_defect;
    logic [2:0] uneq_cnt_reg, rdi_cnt_reg;
    always_ff @(posedge mclk) begin
        if (reset) begin
            unequipped_defect <= 1'b0;
            uneq_cnt_reg <= 3'h0;
        end else if (v5_seen_reg) begin
            if ((label_reg == `VCMON_SL_UNEQ) != unequipped_defect) begin
                if (uneq_cnt_reg == `VCMON_DEF_FRAMES - 3'h1) begin
                    unequipped_defect <= ~unequipped_defect;
                    uneq_cnt_reg <= 3'h0;
                end else begin
                    uneq_cnt_reg <= uneq_cnt_reg + 3'h1;
                end
            end else begin
                uneq_cnt_reg <= 3'h0;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) begin
            remote_defect_defect <= 1'b0;
            rdi_cnt_reg <= 3'h0;
        end else if (gate_fail) begin
            remote_defect_defect <= 1'b0;
            rdi_cnt_reg <= 3'h0;
        end else if (v5_seen_reg) begin
            if (rdi_bit_reg != remote_defect_defect) begin
                if (rdi_cnt_reg == `VCMON_DEF_FRAMES - 3'h1) begin
                    remote_defect_defect <= rdi_bit_reg;
                    rdi_cnt_reg <= 3'h0;
                end else begin
                    rdi_cnt_reg <= rdi_cnt_reg + 3'h1;
                end
            end else begin
                rdi_cnt_reg <= 3'h0;
            end
        end
    end

    // trace capture: 16-byte trace, start byte marked by msb
    logic [7:0] rx_ti_reg [TRACE_LEN];
    logic [7:0] accepted_trace_id [TRACE_LEN];
    logic [7:0] prev_ti_reg [TRACE_LEN];
    logic [3:0] ti_idx_reg;
    logic [1:0] ti_same_reg;
    logic trace_mismatch_defect, ti_zero, ti_match, ti_repeat;
    always_ff @(posedge mclk) begin
        if (reset) begin
            ti_idx_reg <= 4'h0;
            ti_same_reg <= 2'h0;
            for (int i = 0; i < TRACE_LEN; i++) begin
                rx_ti_reg[i] <= 8'h0;
                prev_ti_reg[i] <= 8'h0;
                accepted_trace_id[i] <= 8'h0;
            end
        end else if (j2_done) begin
            rx_ti_reg[cur_byte[7] ? 4'h0 : ti_idx_reg] <= cur_byte;
            ti_idx_reg <= cur_byte[7] ? 4'h1 : ti_idx_reg + 4'h1;
            // a start byte closes the multiframe in rx; accept on the third alike
            if (cur_byte[7]) begin
                ti_same_reg <= ti_repeat ? ((ti_same_reg == 2'h2) ? 2'h2 : ti_same_reg + 2'h1)
                    : 2'h0;
                for (int i = 0; i < TRACE_LEN; i++) begin
                    prev_ti_reg[i] <= rx_ti_reg[i];
                    if (ti_repeat & (ti_same_reg != 2'h0)) accepted_trace_id[i] <= rx_ti_reg[i];
                end
            end
        end
    end
    always_comb begin
        ti_zero = 1'b1;
        ti_match = 1'b1;
        ti_repeat = 1'b1;
        for (int i = 0; i < TRACE_LEN; i++) begin
            ti_zero = ti_zero & (accepted_trace_id[i] == 8'h0);
            ti_match = ti_match & (accepted_trace_id[i] == exp_ti_reg[i]);
            ti_repeat = ti_repeat & (rx_ti_reg[i] == prev_ti_reg[i]);
        end
    end
    always_ff @(posedge mclk) begin
        if (reset) trace_mismatch_defect <= 1'b0;
        else trace_mismatch_defect <= ~mismatch_detect_disable & ~gate_fail & ~ti_match;
    end

    // degraded defect: near-end errored blocks per second at or above threshold
    logic degraded_defect;
    logic [15:0] nebc_acc_reg, febc_acc_reg;
    logic nds_acc_reg, fds_acc_reg;
    always_ff @(posedge mclk) begin
        if (reset) degraded_defect <= 1'b0;
        else if (one_second) degraded_defect <= ~gate_fail & (nebc_acc_reg >= deg_thr_reg);
    end

    // consequent actions and correlations
    logic uneq_zero;
    assign uneq_zero = unequipped_defect & ti_zero;
    always_ff @(posedge mclk) begin
        if (reset) begin
            trail_signal_fail <= 1'b0;
            trail_signal_degrade <= 1'b0;
            cause <= '0;
        end else begin
            trail_signal_fail <= gate_fail | uneq_zero | trace_mismatch_defect;
            trail_signal_degrade <= degraded_defect;
            cause.unequipped_cause <= monitoring_enabled & uneq_zero;
            cause.trace_mismatch_cause <= monitoring_enabled & trace_mismatch_defect & ~uneq_zero;
            cause.degraded_cause <= monitoring_enabled & degraded_defect & ~trace_mismatch_defect;
            cause.remote_defect_cause <= monitoring_enabled & remote_defect_report_en &
                remote_defect_defect & ~trace_mismatch_defect & ~uneq_zero;
            cause.server_fail_cause <= monitoring_enabled & server_fail_report_en & gate_fail;
        end
    end

    // performance accumulation and one-second latch
    always_ff @(posedge mclk) begin
        if (reset) begin
            nebc_acc_reg <= 16'h0;
            febc_acc_reg <= 16'h0;
            nds_acc_reg <= 1'b0;
            fds_acc_reg <= 1'b0;
            perf <= '0;
        end else if (one_second) begin
            perf.near_block_error_count <= nebc_acc_reg;
            perf.far_block_error_count <= febc_acc_reg;
            perf.near_defect_second <= nds_acc_reg;
            perf.far_defect_second <= fds_acc_reg;
            nebc_acc_reg <= 16'h0;
            febc_acc_reg <= 16'h0;
            nds_acc_reg <= 1'b0;
            fds_acc_reg <= 1'b0;
        end else begin
            nebc_acc_reg <= nebc_acc_reg + 16'(near_errored_block & ~&nebc_acc_reg);
            febc_acc_reg <= febc_acc_reg + 16'(far_errored_block & ~&febc_acc_reg);
            nds_acc_reg <= nds_acc_reg | trail_signal_fail | equipment_defect;
            fds_acc_reg <= fds_acc_reg | remote_defect_defect;
        end
    end

    // interrupt events: defect rises and second tick
    logic [`VCMON_IRQ_W-1:0] ev_now, ev_prev_reg, ev_rise, irq_reg;
    assign ev_now = {one_second, degraded_defect, remote_defect_defect,
                     trace_mismatch_defect, unequipped_defect, alarm_indication_defect};
    assign ev_rise = ev_now & ~ev_prev_reg;

    // wishbone slave, ack one cycle after request
    logic req, rd_stat_clr;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // a status read clears exactly the bits it returns, so no event is lost
    assign rd_stat_clr = req & ~wb_we_i & (wb_adr_i == `VCMON_REG_IRQ);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) old[b*8 +: 8] = nw[b*8 +: 8];
        end
        return old;
    endfunction
    logic [3:0] ti_word;
    assign ti_word = wb_adr_i[5:2] - 4'h6;
    always_ff @(posedge mclk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_reg <= `VCMON_CTRL_RST;
            mask_reg <= '0;
            deg_thr_reg <= `VCMON_DEG_THR;
            for (int i = 0; i < TRACE_LEN; i++) exp_ti_reg[i] <= 8'h0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req & wb_we_i) begin
                if (wb_adr_i == `VCMON_REG_CTRL) ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
                else if (wb_adr_i == `VCMON_REG_MASK) mask_reg <= wb_dat_i[`VCMON_IRQ_W-1:0];
                else if (wb_adr_i == `VCMON_REG_DEGT) deg_thr_reg <= wb_dat_i[15:0];
                else if (wb_adr_i >= `VCMON_REG_EXTI && wb_adr_i < `VCMON_REG_ACCEPTED_TRACE_ID) begin
                    for (int b = 0; b < 4; b++) begin
                        if (wb_sel_i[b]) exp_ti_reg[{ti_word[1:0], 2'(b)}] <= wb_dat_i[b*8 +: 8];
                    end
                end
            end else if (req) begin
                if (wb_adr_i == `VCMON_REG_CTRL) wb_dat_o <= ctrl_reg;
                else if (wb_adr_i == `VCMON_REG_STAT) wb_dat_o <= {26'h0, equipment_defect,
                    ev_now[`VCMON_IRQ_W-2:0]} | {16'h0, 16'(label_reg) << 8};
                else if (wb_adr_i == `VCMON_REG_IRQ) wb_dat_o <= 32'(irq_reg);
                else if (wb_adr_i == `VCMON_REG_MASK) wb_dat_o <= 32'(mask_reg);
                else if (wb_adr_i == `VCMON_REG_NEBC) wb_dat_o <= 32'(perf.near_block_error_count);
                else if (wb_adr_i == `VCMON_REG_FEBC) wb_dat_o <= 32'(perf.far_block_error_count);
                else if (wb_adr_i == `VCMON_REG_DEGT) wb_dat_o <= 32'(deg_thr_reg);
                else if (wb_adr_i >= `VCMON_REG_EXTI && wb_adr_i < `VCMON_REG_ACCEPTED_TRACE_ID)
                    for (int b = 0; b < 4; b++) wb_dat_o[b*8 +: 8] <= exp_ti_reg[{ti_word[1:0], 2'(b)}];
                else if (wb_adr_i >= `VCMON_REG_ACCEPTED_TRACE_ID && wb_adr_i < `VCMON_REG_DEGT)
                    for (int b = 0; b < 4; b++)
                        wb_dat_o[b*8 +: 8] <= accepted_trace_id[{2'(ti_word - 4'h4), 2'(b)}];
            end
        end
    end

    // sticky status, set wins over read clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            ev_prev_reg <= '0;
            irq_reg <= '0;
            irq <= 1'b0;
        end else begin
            ev_prev_reg <= ev_now;
            irq_reg <= (rd_stat_clr ? '0 : irq_reg) | ev_rise;
            irq <= |(irq_reg & mask_reg);
        end
    end

    // ais raise needs five label-111 frames in a row
    ais_set_a: assert property (@(posedge mclk) disable iff (reset)
        $rose(alarm_indication_defect) |-> label_reg == `VCMON_SL_AIS)
        else $error("ais raised without label 111");
    ais_clear_a: assert property (@(posedge mclk) disable iff (reset)
        $fell(alarm_indication_defect) |-> label_reg != `VCMON_SL_AIS)
        else $error("ais cleared on label 111");
    tsf_follow_a: assert property (@(posedge mclk) disable iff (reset)
        (s_ssf | alarm_indication_defect) |=> trail_signal_fail)
        else $error("trail fail missing");
    uneq_cause_a: assert property (@(posedge mclk) disable iff (reset)
        cause.unequipped_cause |-> $past(monitoring_enabled))
        else $error("unequipped cause while unmonitored");
    tim_cause_a: assert property (@(posedge mclk) disable iff (reset)
        cause.trace_mismatch_cause |-> $past(trace_mismatch_defect))
        else $error("mismatch cause without defect");
    deg_cause_a: assert property (@(posedge mclk) disable iff (reset)
        cause.degraded_cause |-> !$past(trace_mismatch_defect))
        else $error("degraded cause with mismatch");
    rdi_cause_a: assert property (@(posedge mclk) disable iff (reset)
        cause.remote_defect_cause |-> $past(remote_defect_report_en))
        else $error("remote cause not enabled");
    ssf_cause_a: assert property (@(posedge mclk) disable iff (reset)
        (monitoring_enabled & server_fail_report_en & s_ssf) |=> cause.server_fail_cause)
        else $error("server cause missing");
    tim_dis_a: assert property (@(posedge mclk) disable iff (reset)
        mismatch_detect_disable |=> !trace_mismatch_defect)
        else $error("mismatch despite disable");
    sec_clear_a: assert property (@(posedge mclk) disable iff (reset)
        one_second |=> nebc_acc_reg == 16'h0)
        else $error("accumulator not cleared");
endmodule // vcmon_top

// ### sim/vcmon_src.sv
// behavioural vc-12 path source feeding the monitor stream
module vcmon_src #(
    parameter int NB = 8
) (
    // stream toward the monitor
    output logic ci_clk,
    output logic ci_data,
    output logic ci_fs,
    output int frames,
    // overhead content set by the bench
    input wire logic go,
    input wire logic [2:0] label,
    input wire logic rei,
    input wire logic rdi,
    input wire logic bip_err
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock still until go, then frames back to back, v5 first
    initial begin
        logic [7:0] b;
        logic [1:0] par;
        ci_clk = 1'b0;
        ci_data = 1'b0;
        ci_fs = 1'b0;
        frames = 0;
        par = 2'h0;
        wait (go);
        forever begin
            #8;
            for (int i = 0; i < NB; i++) begin
                // v5: bip of last frame rei label rdi
                b = (i == 0) ? {par[1] ^ bip_err, par[0], rei, 1'b0, label, rdi} : 8'(i * 8'h5b);
                if (i == 0)
                    par = 2'h0;
                par ^= {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
                for (int k = 7; k >= 0; k--) begin
                    ci_data = b[k];
                    ci_fs = (i == 0) && (k == 7);
                    #80 ci_clk = 1'b1;
                    #80 ci_clk = 1'b0;
                end
            end
            frames++;
        end
    end
endmodule // vcmon_src

// ### sim/vcmon_top_tb.sv
// self-checking bench for the vc-12 path monitor
module vcmon_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, reset = 1'b1, one_second = 1'b0, isf = 1'b0, eqd = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, rei = 1'b0, rdi = 1'b0, bip = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [2:0] label = 3'h2;
    logic [31:0] dat = 32'h0, q, dat_o;
    logic ack, tsf, tsd, irq, ci_clk, ci_data, ci_fs;
    vcmon_pkg::vcmon_cause_s cause;
    vcmon_pkg::vcmon_perf_s perf;
    int n_fail = 0, checks = 0, frames;
    // 250 mhz clock
    initial begin
        forever #2 mclk = ~mclk;
    end
    // short frames keep the run brief
    vcmon_top #(.FRAME_BYTES(8)) u_dut (.mclk(mclk), .reset(reset), .ci_data(ci_data),
        .ci_clk(ci_clk), .ci_frame_start(ci_fs), .incoming_server_fail(isf),
        .one_second(one_second), .equipment_defect(eqd), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .trail_signal_fail(tsf), .trail_signal_degrade(tsd), .cause(cause),
        .perf(perf), .irq(irq));
    vcmon_src #(.NB(8)) u_src (.ci_clk(ci_clk), .ci_data(ci_data), .ci_fs(ci_fs),
        .frames(frames), .go(go), .label(label), .rei(rei), .rdi(rdi), .bip_err(bip));
    // compare and count
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // wait for n more frames, return on the edge after
    task automatic wf(input int n);
        int t;
        t = frames + n;
        wait (frames >= t);
        @(posedge mclk);
    endtask
    // verdict and end of run
    task automatic wrap_up;
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // alarm indication raise, then clear into unequipped by label persistence
    task automatic t_ais;
        label <= 3'h7;
        wf(4);
        chk(tsf, 0);
        wf(1);
        chk({tsf, cause}, 6'h21);
        label <= 3'h0;
        wf(4);
        chk({tsf, cause}, 6'h21);
        wf(1);
        label <= 3'h2;
        chk({tsd, tsf, cause}, 7'h30);
        wb(1, 8'h0c, 32'h1);
        @(posedge mclk);
        chk(irq, 1);
        wb(0, 8'h08, 0);
        chk(q[1:0], 2'h3);
        wb(0, 8'h08, 0);
        chk({irq, q[1:0]}, 0);
        wf(5);
        chk({tsf, cause}, 0);
    endtask
    // server fail and monitoring mode gating
    task automatic t_ssf;
        isf <= 1'b1;
        repeat (10) @(posedge mclk);
        chk({tsf, cause}, 6'h21);
        wb(1, 8'h00, 32'h0e);
        repeat (4) @(posedge mclk);
        chk({tsf, cause}, 6'h20);
        wb(1, 8'h00, 32'h1e);
        isf <= 1'b0;
        repeat (10) @(posedge mclk);
        chk(tsf, 0);
        wb(1, 8'h18, 32'h5a);
        wb(1, 8'h00, 32'h1c);
        repeat (4) @(posedge mclk);
        chk({tsf, cause}, 6'h28);
        wb(1, 8'h00, 32'h1e);
        repeat (4) @(posedge mclk);
        chk(tsf, 0);
    endtask
    // one parity error, six remote errors, remote defect over one second
    task automatic t_perf;
        wf(1);
        one_second <= 1'b1;
        {rei, rdi, bip, eqd} <= 4'hf;
        @(posedge mclk);
        one_second <= 1'b0;
        wf(1);
        bip <= 1'b0;
        wf(5);
        rei <= 1'b0;
        chk(cause, 5'h02);
        wb(1, 8'h38, 32'h1);
        wf(1);
        one_second <= 1'b1;
        @(posedge mclk);
        one_second <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(perf, {2'b11, 16'h1, 16'h6});
        chk({tsd, cause}, 6'h26);
    endtask
    // watchdog
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        wb(0, 8'h00, 0);
        chk(q, 32'h1);
        wb(0, 8'hfc, 0);
        chk(q, 0);
        wb(1, 8'h00, 32'h1e); // monitored, reports on, mismatch detect off
        wb(0, 8'h28, 0);
        chk(q, 0);
        go <= 1'b1;
        wf(2);
        chk({tsf, cause}, 0);
        t_ais();
        t_ssf();
        t_perf();
        wrap_up();
    end
endmodule // vcmon_top_tb
